// ===== ast_pkg.sv
// Purpose: Shared constants for the asynchronous SRAM cycle controller.
// Assumes: 40 MHz controller clock; times held in ns as printed.
// Notes:   Cycle counts are derived from these times in the top module.
package ast_pkg;

  // Controller clock
  localparam int CLK_PERIOD_NS = 25;

  // Default widths
  localparam int ADDR_W_DEF = 17;
  localparam int DATA_W_DEF = 16;
  localparam int CNT_W_DEF  = 4;
  localparam int LANES      = 2;

  // Read timing, faster and slower grade (ns)
  localparam int READ_CYCLE_FAST_NS      = 45;
  localparam int READ_CYCLE_SLOW_NS      = 55;
  localparam int ADDR_ACCESS_FAST_NS     = 45;
  localparam int ADDR_ACCESS_SLOW_NS     = 55;
  localparam int READ_HOLD_NS            = 10;
  localparam int DRIVE_VALID_FAST_NS     = 22;
  localparam int DRIVE_VALID_SLOW_NS     = 25;
  localparam int SELECT_VALID_FAST_NS    = 45;
  localparam int SELECT_VALID_SLOW_NS    = 55;
  localparam int LANE_VALID_FAST_NS      = 45;
  localparam int LANE_VALID_SLOW_NS      = 55;
  localparam int SELECT_FLOAT_FAST_NS    = 18;
  localparam int SELECT_FLOAT_SLOW_NS    = 20;

  // Write timing, faster and slower grade (ns)
  localparam int WRITE_CYCLE_FAST_NS     = 45;
  localparam int WRITE_CYCLE_SLOW_NS     = 55;
  localparam int ADDR_SETUP_END_FAST_NS  = 35;
  localparam int ADDR_SETUP_END_SLOW_NS  = 40;
  localparam int ADDR_SETUP_BEGIN_NS     = 0;
  localparam int ADDR_HOLD_END_NS        = 0;
  localparam int WRITE_PULSE_FAST_NS     = 35;
  localparam int WRITE_PULSE_SLOW_NS     = 40;
  localparam int LANE_LOW_END_FAST_NS    = 35;
  localparam int LANE_LOW_END_SLOW_NS    = 40;
  localparam int WDATA_SETUP_END_NS      = 25;
  localparam int WDATA_HOLD_END_NS       = 0;
  localparam int STROBE_FLOAT_FAST_NS    = 18;
  localparam int STROBE_FLOAT_SLOW_NS    = 20;

  // Retention timing (ns)
  localparam int DESELECT_TO_RET_NS      = 0;
  localparam int RECOVERY_FAST_NS        = 45;
  localparam int RECOVERY_SLOW_NS        = 55;

  // Idle level of every active-low strobe
  localparam logic STROBE_OFF = 1'b1;
  localparam logic STROBE_ON  = 1'b0;

  // Least whole cycles covering a minimum time, never below one
  function automatic int min_cyc(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction : min_cyc

  function automatic int max2(input int a, input int b);
    return (a > b) ? a : b;
  endfunction : max2

  function automatic int pick(input bit fast, input int f, input int s);
    return fast ? f : s;
  endfunction : pick

endpackage : ast_pkg

// ===== ast_tmr.sv
// Purpose: Down counter that times one controller phase.
// Assumes: count_in is at least one when load_in is high.
// Notes:   Loaded with N, expired_out rises in the N-th cycle after load.
module ast_tmr #(
  parameter int CNT_W = ast_pkg::CNT_W_DEF
) (
  // Clock and control
  input  wire logic             clk_in,
  input  wire logic             sys_rst_in,
  input  wire logic             ce_in,
  // Load and status
  input  wire logic             load_in,
  input  wire logic [CNT_W-1:0] count_in,
  output logic                  expired_out
);

  localparam logic [CNT_W-1:0] ONE = {{(CNT_W-1){1'b0}}, 1'b1};

  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;

  always_comb begin
    next_cnt = cnt;
    if (load_in) begin
      next_cnt = count_in;
    end else if (cnt != '0) begin
      next_cnt = cnt - ONE;
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      cnt <= '0;
    end else if (ce_in) begin
      cnt <= next_cnt;
    end
  end

  // Zero also counts as expired so a stale timer never hangs the caller
  assign expired_out = (cnt <= ONE);

endmodule : ast_tmr

// ===== ast_ctrl.sv
// Purpose: Host controller sequencing an asynchronous 16-bit SRAM.
// Assumes: sram_data_in is synchronous to clk_in; one clock domain.
// Notes:   Output drive stays off during writes to avoid bus fights.
//
// Operation
// [R1] Write happens only while strobe, select and a lane are all low.
// [R2] Write ends at first strobe release; setup counts to that edge.
// [R3] Memory is deselected by high select or both lanes high.
// [R4] Lane enables change only together with chip select edges.
// [R5] With drive low, write pulse covers data setup plus float time.
// [R6] Read data sampled no earlier than the address access delay.
// [R7] Previous read data stays driven 10 ns after address change.
// [R8] Read data valid within drive-to-valid delay after drive low.
// [R9] Read data valid within select delay after select goes low.
// [R10] Lane data valid within lane delay after that lane goes low.
// [R11] Address stable the address-setup-to-end time before write end.
// [R12] Address valid by write start; zero setup suffices.
// [R13] Address may change at the write-ending edge.
// [R14] Write data stable the data setup time before write end.
// [R15] Write data released at the edge ending the write.
// [R16] Write lane low for the lane-low-to-end time before write end.
// [R17] Memory deselected before retention is granted.
// [R18] Joint lane switching leaves outputs floating for 10 ns.
// [R19] Every minimum rounds up to whole clocks, never shorter.
module ast_ctrl #(
  parameter int ADDR_W     = ast_pkg::ADDR_W_DEF,
  parameter int DATA_W     = ast_pkg::DATA_W_DEF,
  parameter int CNT_W      = ast_pkg::CNT_W_DEF,
  parameter bit FAST_GRADE = 1'b1
) (
  // Clock, reset, enable
  input  wire logic                     clk_in,
  input  wire logic                     sys_rst_in,
  input  wire logic                     ce_in,
  // User request
  input  wire logic                     req_in,
  input  wire logic                     req_write_in,
  input  wire logic [ADDR_W-1:0]        req_addr_in,
  input  wire logic [DATA_W-1:0]        req_wdata_in,
  input  wire logic [ast_pkg::LANES-1:0] req_lanes_in,
  output logic                          ready_out,
  // User answer
  output logic [DATA_W-1:0]             rdata_out,
  output logic                          rvalid_out,
  output logic                          wdone_out,
  // Retention handshake
  input  wire logic                     sleep_req_in,
  output logic                          retention_ok_out,
  // Memory pins
  output logic [ADDR_W-1:0]             sram_addr_out,
  output logic                          chip_select_n_out,
  output logic                          write_strobe_n_out,
  output logic                          output_drive_n_out,
  output logic                          upper_byte_enable_n_out,
  output logic                          lower_byte_enable_n_out,
  output logic [DATA_W-1:0]             sram_data_out,
  output logic                          sram_data_oe_out,
  input  wire logic [DATA_W-1:0]        sram_data_in
);

  // Grade-specific times
  localparam bit G = FAST_GRADE;
  localparam int RD_CYCLE_NS = ast_pkg::pick(G,
    ast_pkg::READ_CYCLE_FAST_NS, ast_pkg::READ_CYCLE_SLOW_NS);
  localparam int ACCESS_NS = ast_pkg::max2(
    ast_pkg::max2(
      ast_pkg::pick(G, ast_pkg::ADDR_ACCESS_FAST_NS,
                       ast_pkg::ADDR_ACCESS_SLOW_NS),
      ast_pkg::pick(G, ast_pkg::SELECT_VALID_FAST_NS,
                       ast_pkg::SELECT_VALID_SLOW_NS)),
    ast_pkg::max2(
      ast_pkg::pick(G, ast_pkg::LANE_VALID_FAST_NS,
                       ast_pkg::LANE_VALID_SLOW_NS),
      ast_pkg::pick(G, ast_pkg::DRIVE_VALID_FAST_NS,
                       ast_pkg::DRIVE_VALID_SLOW_NS)));
  localparam int FLOAT_NS = ast_pkg::pick(G,
    ast_pkg::SELECT_FLOAT_FAST_NS, ast_pkg::SELECT_FLOAT_SLOW_NS);
  localparam int WR_CYCLE_NS = ast_pkg::pick(G,
    ast_pkg::WRITE_CYCLE_FAST_NS, ast_pkg::WRITE_CYCLE_SLOW_NS);
  localparam int PULSE_NS = ast_pkg::max2(
    ast_pkg::max2(
      ast_pkg::pick(G, ast_pkg::WRITE_PULSE_FAST_NS,
                       ast_pkg::WRITE_PULSE_SLOW_NS),
      ast_pkg::pick(G, ast_pkg::ADDR_SETUP_END_FAST_NS,
                       ast_pkg::ADDR_SETUP_END_SLOW_NS)),
    ast_pkg::max2(
      ast_pkg::pick(G, ast_pkg::LANE_LOW_END_FAST_NS,
                       ast_pkg::LANE_LOW_END_SLOW_NS),
      ast_pkg::WDATA_SETUP_END_NS + ast_pkg::pick(G,
        ast_pkg::STROBE_FLOAT_FAST_NS, ast_pkg::STROBE_FLOAT_SLOW_NS)));
  localparam int RECOV_NS = ast_pkg::pick(G,
    ast_pkg::RECOVERY_FAST_NS, ast_pkg::RECOVERY_SLOW_NS);

  // [R19] rounded cycle counts
  localparam int READ_INT  = ast_pkg::min_cyc(
    ast_pkg::max2(ACCESS_NS, RD_CYCLE_NS));
  localparam int PULSE_INT = ast_pkg::min_cyc(PULSE_NS);
  localparam int WCYC_INT  = ast_pkg::min_cyc(WR_CYCLE_NS);
  localparam int WGAP_INT  = (WCYC_INT > PULSE_INT) ?
                             (WCYC_INT - PULSE_INT) : 0;
  localparam int TURN_INT  = ast_pkg::min_cyc(FLOAT_NS);
  localparam int RET_INT   = ast_pkg::min_cyc(ast_pkg::DESELECT_TO_RET_NS);
  localparam int RECOV_INT = ast_pkg::min_cyc(RECOV_NS);

  localparam logic [CNT_W-1:0] READ_CNT  = CNT_W'(READ_INT);
  localparam logic [CNT_W-1:0] PULSE_CNT = CNT_W'(PULSE_INT);
  localparam logic [CNT_W-1:0] WGAP_CNT  = CNT_W'(WGAP_INT);
  localparam logic [CNT_W-1:0] TURN_CNT  = CNT_W'(TURN_INT);
  localparam logic [CNT_W-1:0] RET_CNT   = CNT_W'(RET_INT);
  localparam logic [CNT_W-1:0] RECOV_CNT = CNT_W'(RECOV_INT);

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_READ,
    ST_WRITE,
    ST_GAP,
    ST_DESEL,
    ST_RETAIN
  } ast_state_e;

  // State and registered pins
  ast_state_e          state;
  ast_state_e          next_state;
  logic [ADDR_W-1:0]   addr;
  logic [ADDR_W-1:0]   next_addr;
  logic                cs_n;
  logic                next_cs_n;
  logic                we_n;
  logic                next_we_n;
  logic                oe_n;
  logic                next_oe_n;
  logic                ube_n;
  logic                next_ube_n;
  logic                lbe_n;
  logic                next_lbe_n;
  logic [DATA_W-1:0]   wdata;
  logic [DATA_W-1:0]   next_wdata;
  logic                wdata_oe;
  logic                next_wdata_oe;
  logic [DATA_W-1:0]   rdata;
  logic [DATA_W-1:0]   next_rdata;
  logic                rvalid;
  logic                next_rvalid;
  logic                wdone;
  logic                next_wdone;
  logic                ready;
  logic                next_ready;
  logic                ret_ok;
  logic                next_ret_ok;
  logic                tmr_load;
  logic [CNT_W-1:0]    tmr_count;
  logic                tmr_expired;

  ast_tmr #(
    .CNT_W (CNT_W)
  ) u_tmr (
    .clk_in      (clk_in),
    .sys_rst_in  (sys_rst_in),
    .ce_in       (ce_in),
    .load_in     (tmr_load),
    .count_in    (tmr_count),
    .expired_out (tmr_expired)
  );

  always_comb begin
    next_state    = state;
    next_addr     = addr;
    next_cs_n     = cs_n;
    next_we_n     = we_n;
    next_oe_n     = oe_n;
    next_ube_n    = ube_n;
    next_lbe_n    = lbe_n;
    next_wdata    = wdata;
    next_wdata_oe = wdata_oe;
    next_rdata    = rdata;
    next_rvalid   = 1'b0;
    next_wdone    = 1'b0;
    next_ret_ok   = ret_ok;
    tmr_load      = 1'b0;
    tmr_count     = '0;
    unique case (state)
      ST_IDLE: begin
        if (sleep_req_in) begin
          // [R17] deselect first
          next_cs_n  = ast_pkg::STROBE_OFF;
          next_ube_n = ast_pkg::STROBE_OFF;
          next_lbe_n = ast_pkg::STROBE_OFF;
          tmr_load   = 1'b1;
          tmr_count  = RET_CNT;
          next_state = ST_DESEL;
        end else if (req_in) begin
          // [R12] address with select
          next_addr  = req_addr_in;
          next_cs_n  = ast_pkg::STROBE_ON;
          // [R4] lanes move with select
          next_ube_n = ~req_lanes_in[1];
          next_lbe_n = ~req_lanes_in[0];
          if (req_write_in) begin
            // [R1] write strobe, select and requested lanes low together
            next_we_n     = ast_pkg::STROBE_ON;
            next_wdata    = req_wdata_in;
            next_wdata_oe = 1'b1;
            tmr_load      = 1'b1;
            // [R5] pulse covers setup and float
            tmr_count     = PULSE_CNT;
            next_state    = ST_WRITE;
          end else begin
            next_oe_n  = ast_pkg::STROBE_ON;
            tmr_load   = 1'b1;
            tmr_count  = READ_CNT;
            next_state = ST_READ;
          end
        end
      end
      ST_READ: begin
        // [R6] sample after access delay
        // [R8] drive delay is covered too
        // [R9] select delay is covered too
        // [R10] lane delay is covered too
        if (tmr_expired) begin
          next_rdata  = sram_data_in;
          next_rvalid = 1'b1;
          // [R3] deselect ends the read
          next_cs_n   = ast_pkg::STROBE_OFF;
          next_oe_n   = ast_pkg::STROBE_OFF;
          next_ube_n  = ast_pkg::STROBE_OFF;
          next_lbe_n  = ast_pkg::STROBE_OFF;
          // Let the memory float before anyone drives the bus again
          tmr_load    = 1'b1;
          tmr_count   = TURN_CNT;
          next_state  = ST_GAP;
        end
      end
      ST_WRITE: begin
        // [R11] address held through pulse
        // [R14] data held through pulse
        // [R16] lane low through pulse
        if (tmr_expired) begin
          // [R2] all strobes end on one edge
          next_we_n     = ast_pkg::STROBE_OFF;
          next_cs_n     = ast_pkg::STROBE_OFF;
          next_ube_n    = ast_pkg::STROBE_OFF;
          next_lbe_n    = ast_pkg::STROBE_OFF;
          // [R15] release data at end
          next_wdata_oe = 1'b0;
          next_wdone    = 1'b1;
          if (WGAP_CNT != '0) begin
            tmr_load   = 1'b1;
            tmr_count  = WGAP_CNT;
            next_state = ST_GAP;
          end else begin
            next_state = ST_IDLE;
          end
        end
      end
      ST_GAP: begin
        if (tmr_expired) begin
          next_state = ST_IDLE;
        end
      end
      ST_DESEL: begin
        // [R17] grant only when deselected
        if (tmr_expired) begin
          next_ret_ok = 1'b1;
          next_state  = ST_RETAIN;
        end
      end
      ST_RETAIN: begin
        if (!sleep_req_in) begin
          // Supply may still be ramping; wait the recovery time
          next_ret_ok = 1'b0;
          tmr_load    = 1'b1;
          tmr_count   = RECOV_CNT;
          next_state  = ST_GAP;
        end
      end
    endcase
    next_ready = (next_state == ST_IDLE) && !sleep_req_in;
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      state    <= ST_IDLE;
      addr     <= '0;
      cs_n     <= ast_pkg::STROBE_OFF;
      we_n     <= ast_pkg::STROBE_OFF;
      oe_n     <= ast_pkg::STROBE_OFF;
      ube_n    <= ast_pkg::STROBE_OFF;
      lbe_n    <= ast_pkg::STROBE_OFF;
      wdata    <= '0;
      wdata_oe <= 1'b0;
      rdata    <= '0;
      rvalid   <= 1'b0;
      wdone    <= 1'b0;
      ready    <= 1'b0;
      ret_ok   <= 1'b0;
    end else if (ce_in) begin
      state    <= next_state;
      addr     <= next_addr;
      cs_n     <= next_cs_n;
      we_n     <= next_we_n;
      oe_n     <= next_oe_n;
      ube_n    <= next_ube_n;
      lbe_n    <= next_lbe_n;
      wdata    <= next_wdata;
      wdata_oe <= next_wdata_oe;
      rdata    <= next_rdata;
      rvalid   <= next_rvalid;
      wdone    <= next_wdone;
      ready    <= next_ready;
      ret_ok   <= next_ret_ok;
    end
  end

  // [R13] address may move at end edge
  assign sram_addr_out           = addr;
  assign chip_select_n_out       = cs_n;
  assign write_strobe_n_out      = we_n;
  assign output_drive_n_out      = oe_n;
  assign upper_byte_enable_n_out = ube_n;
  assign lower_byte_enable_n_out = lbe_n;
  assign sram_data_out           = wdata;
  assign sram_data_oe_out        = wdata_oe;
  assign rdata_out               = rdata;
  assign rvalid_out              = rvalid;
  assign wdone_out               = wdone;
  assign ready_out               = ready;
  assign retention_ok_out        = ret_ok;

endmodule : ast_ctrl

// ===== ast_ctrl_properties.sv
// Purpose: Pin timing checks for the SRAM cycle controller.
// Assumes: Bound to ast_ctrl; one clock domain.
// Notes:   Read latency follows the grade parameter.
module ast_ctrl_properties #(
  parameter int ADDR_W     = 17,
  parameter int DATA_W     = 16,
  parameter bit FAST_GRADE = 1'b1
) (
  // Clock and reset
  input  wire logic              clk_in,
  input  wire logic              sys_rst_in,
  // User side
  input  wire logic              ready_out,
  input  wire logic [DATA_W-1:0] rdata_out,
  input  wire logic              rvalid_out,
  input  wire logic              wdone_out,
  input  wire logic              sleep_req_in,
  input  wire logic              retention_ok_out,
  // Memory pins
  input  wire logic [ADDR_W-1:0] sram_addr_out,
  input  wire logic              chip_select_n_out,
  input  wire logic              write_strobe_n_out,
  input  wire logic              output_drive_n_out,
  input  wire logic              upper_byte_enable_n_out,
  input  wire logic              lower_byte_enable_n_out,
  input  wire logic [DATA_W-1:0] sram_data_out,
  input  wire logic              sram_data_oe_out,
  input  wire logic [DATA_W-1:0] sram_data_in
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int RD_CYC = FAST_GRADE ? 2 : 3;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);

  chk_write_pulse_len: assert property ($fell(write_strobe_n_out) |->
    (!write_strobe_n_out && !chip_select_n_out) [*2] ##1 write_strobe_n_out)
    else $error("write strobe pulse length wrong");
  chk_write_end_edge: assert property ($rose(write_strobe_n_out) |->
    wdone_out && !sram_data_oe_out && chip_select_n_out)
    else $error("write end edge not aligned");
  chk_write_start: assert property ($fell(write_strobe_n_out) |->
    sram_data_oe_out && !chip_select_n_out && output_drive_n_out)
    else $error("write start without address and data");
  chk_drive_off_write: assert property (!write_strobe_n_out |->
    output_drive_n_out)
    else $error("output drive low during write");
  chk_addr_held: assert property ((!write_strobe_n_out &&
    !$past(write_strobe_n_out)) |-> $stable(sram_addr_out))
    else $error("address moved inside write");
  chk_wdata_held: assert property ((!write_strobe_n_out &&
    !$past(write_strobe_n_out)) |->
    $stable(sram_data_out) && sram_data_oe_out)
    else $error("write data moved inside write");
  chk_lanes_with_select: assert property (
    ($changed(upper_byte_enable_n_out) ||
     $changed(lower_byte_enable_n_out)) |-> $changed(chip_select_n_out))
    else $error("lane enable moved while deselected");
  chk_read_timing: assert property ($fell(output_drive_n_out) |->
    !chip_select_n_out ##RD_CYC (rvalid_out && output_drive_n_out))
    else $error("read completed at wrong cycle");
  chk_read_capture: assert property (rvalid_out |->
    rdata_out == $past(sram_data_in))
    else $error("read data not taken from memory bus");
  chk_retention_desel: assert property (retention_ok_out |->
    chip_select_n_out && upper_byte_enable_n_out && lower_byte_enable_n_out)
    else $error("retention granted while selected");
  chk_retention_grant: assert property (
    ($rose(sleep_req_in) && ready_out) |-> ##[1:2] retention_ok_out)
    else $error("retention not granted in time");
endmodule : ast_ctrl_properties

bind ast_ctrl ast_ctrl_properties #(
  .ADDR_W(ADDR_W), .DATA_W(DATA_W), .FAST_GRADE(FAST_GRADE)
) ast_ctrl_properties_inst (
  .clk_in(clk_in), .sys_rst_in(sys_rst_in), .ready_out(ready_out),
  .rdata_out(rdata_out), .rvalid_out(rvalid_out), .wdone_out(wdone_out),
  .sleep_req_in(sleep_req_in), .retention_ok_out(retention_ok_out),
  .sram_addr_out(sram_addr_out), .chip_select_n_out(chip_select_n_out),
  .write_strobe_n_out(write_strobe_n_out),
  .output_drive_n_out(output_drive_n_out),
  .upper_byte_enable_n_out(upper_byte_enable_n_out),
  .lower_byte_enable_n_out(lower_byte_enable_n_out),
  .sram_data_out(sram_data_out), .sram_data_oe_out(sram_data_oe_out),
  .sram_data_in(sram_data_in)
);

// ===== ast_sram_model.sv
// Purpose: Behavioural asynchronous 16-bit memory for the bench.
// Assumes: Only the low 8 address bits are decoded.
// Notes:   Floating outputs show inverted data so stale reads are caught.
module ast_sram_model #(
  parameter int ACC_NS  = 45,
  parameter int HOLD_NS = 10
) (
  // Memory pins
  input  wire logic [16:0] addr_in,
  input  wire logic        cs_n_in,
  input  wire logic        we_n_in,
  input  wire logic        oe_n_in,
  input  wire logic        upper_byte_enable_n_in,
  input  wire logic        lower_byte_enable_n_in,
  input  wire logic [15:0] dq_in,
  output logic      [15:0] q_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [0:255];
  logic [15:0] rd_val;
  logic        wr_act;
  wire  [15:0] wd_d;
  wire  [16:0] wa_d;
  wire  [1:0]  wl_d;
  // Delayed copies keep the values from just before the ending edge
  assign #1 wd_d = dq_in;
  assign #1 wa_d = addr_in;
  assign #1 wl_d = {~upper_byte_enable_n_in, ~lower_byte_enable_n_in};
  assign wr_act = !we_n_in && !cs_n_in &&
                  !(upper_byte_enable_n_in && lower_byte_enable_n_in);
  initial begin
    for (int i = 0; i < 256; i++) mem[i] = 16'h0000;
    q_out = 16'h0000;
  end
  always @(negedge wr_act) begin
    if (wl_d[1] === 1'b1) mem[wa_d[7:0]][15:8] = wd_d[15:8];
    if (wl_d[0] === 1'b1) mem[wa_d[7:0]][7:0] = wd_d[7:0];
  end
  always @(addr_in, cs_n_in, oe_n_in, we_n_in, upper_byte_enable_n_in,
           lower_byte_enable_n_in) begin
    rd_val = ~q_out;
    if (!cs_n_in && !oe_n_in && we_n_in) begin
      if (!upper_byte_enable_n_in) rd_val[15:8] = mem[addr_in[7:0]][15:8];
      if (!lower_byte_enable_n_in) rd_val[7:0] = mem[addr_in[7:0]][7:0];
    end
    q_out <= #(HOLD_NS) ~q_out;
    q_out <= #(ACC_NS) rd_val;
  end
endmodule : ast_sram_model

// ===== ast_ctrl_tb.sv
// Purpose: Self-checking bench for the SRAM cycle controller.
// Assumes: Fast grade, 40 MHz clock, inputs driven on falling edges.
// Notes:   Pin timing is judged by the bound checker.
module ast_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_in, sys_rst_in, ce_in, req_in, req_write_in;
  logic [16:0] req_addr_in, sram_addr_out;
  logic [15:0] req_wdata_in, rdata_out, sram_data_out, sram_data_in, dev_q;
  logic [1:0]  req_lanes_in;
  logic        ready_out, rvalid_out, wdone_out, sleep_req_in;
  logic        retention_ok_out, cs_n, we_n, oe_n, ub_n, lb_n, data_oe;
  int          errors = 0;
  int          check_count = 0;
  int          cycles = 0;

  ast_ctrl ast_ctrl_inst (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .ce_in(ce_in),
    .req_in(req_in), .req_write_in(req_write_in), .req_addr_in(req_addr_in),
    .req_wdata_in(req_wdata_in), .req_lanes_in(req_lanes_in),
    .ready_out(ready_out), .rdata_out(rdata_out), .rvalid_out(rvalid_out),
    .wdone_out(wdone_out), .sleep_req_in(sleep_req_in),
    .retention_ok_out(retention_ok_out), .sram_addr_out(sram_addr_out),
    .chip_select_n_out(cs_n), .write_strobe_n_out(we_n),
    .output_drive_n_out(oe_n), .upper_byte_enable_n_out(ub_n),
    .lower_byte_enable_n_out(lb_n), .sram_data_out(sram_data_out),
    .sram_data_oe_out(data_oe), .sram_data_in(sram_data_in));
  ast_sram_model ast_sram_model_inst (
    .addr_in(sram_addr_out), .cs_n_in(cs_n), .we_n_in(we_n),
    .oe_n_in(oe_n), .upper_byte_enable_n_in(ub_n),
    .lower_byte_enable_n_in(lb_n), .dq_in(sram_data_in), .q_out(dev_q));
  // Shared data wire: controller wins while it drives
  assign sram_data_in = data_oe ? sram_data_out : dev_q;

  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end

  task automatic tally_and_finish();
    if (errors == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish

  task automatic cmp_word(input string what, input logic [15:0] exp,
                          input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp_word

  task automatic cmp_flag(input string what, input logic exp, input logic got);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
    end
  endtask : cmp_flag

  task automatic issue(input logic w, input logic [16:0] a,
                       input logic [15:0] d, input logic [1:0] ln);
    int n;
    n = 0;
    while (ready_out !== 1'b1 && n < 40) begin
      @(negedge clk_in);
      n++;
    end
    cmp_flag("ready", 1'b1, ready_out);
    req_in = 1'b1;
    req_write_in = w;
    req_addr_in = a;
    req_wdata_in = d;
    req_lanes_in = ln;
    @(negedge clk_in);
    req_in = 1'b0;
    cmp_flag("ready_busy", 1'b0, ready_out);
  endtask : issue

  task automatic do_write(input logic [16:0] a, input logic [15:0] d,
                          input logic [1:0] ln);
    issue(1'b1, a, d, ln);
    repeat (2) @(negedge clk_in);
    cmp_flag("wdone", 1'b1, wdone_out);
    @(negedge clk_in);
    cmp_flag("wdone_end", 1'b0, wdone_out);
  endtask : do_write

  task automatic do_read(input logic [16:0] a, input logic [1:0] ln,
                         input logic [15:0] exp);
    logic [15:0] m;
    m = {{8{ln[1]}}, {8{ln[0]}}};
    issue(1'b0, a, 16'h0000, ln);
    repeat (2) @(negedge clk_in);
    cmp_flag("rvalid", 1'b1, rvalid_out);
    cmp_word("rdata", exp & m, rdata_out & m);
    @(negedge clk_in);
    cmp_flag("rvalid_end", 1'b0, rvalid_out);
  endtask : do_read

  task automatic t_lanes();
    do_write(17'h1_0012, 16'h1234, 2'b11);
    do_write(17'h1_0012, 16'habff, 2'b10);
    do_write(17'h1_0012, 16'hffcd, 2'b01);
    do_write(17'h1_0012, 16'h0000, 2'b00);
    do_read(17'h1_0012, 2'b11, 16'habcd);
    do_read(17'h1_0012, 2'b01, 16'h00cd);
  endtask : t_lanes

  task automatic t_back_to_back();
    do_write(17'h0_0040, 16'h5a5a, 2'b11);
    do_write(17'h0_0041, 16'ha5a5, 2'b11);
    do_read(17'h0_0040, 2'b11, 16'h5a5a);
    do_read(17'h0_0041, 2'b11, 16'ha5a5);
  endtask : t_back_to_back

  task automatic t_sleep();
    sleep_req_in = 1'b1;
    req_in = 1'b1;
    req_write_in = 1'b0;
    repeat (3) @(negedge clk_in);
    cmp_flag("retention_ok", 1'b1, retention_ok_out);
    cmp_flag("select_n", 1'b1, cs_n);
    cmp_flag("ready_sleep", 1'b0, ready_out);
    cmp_flag("rvalid_sleep", 1'b0, rvalid_out);
    sleep_req_in = 1'b0;
    req_in = 1'b0;
    @(negedge clk_in);
    cmp_flag("retention_off", 1'b0, retention_ok_out);
    do_read(17'h0_0041, 2'b11, 16'ha5a5);
  endtask : t_sleep

  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      tally_and_finish();
    end
  end

  initial begin
    sys_rst_in = 1'b1;
    ce_in = 1'b1;
    req_in = 1'b0;
    req_write_in = 1'b0;
    req_addr_in = 17'h0_0000;
    req_wdata_in = 16'h0000;
    req_lanes_in = 2'b00;
    sleep_req_in = 1'b0;
    repeat (6) @(negedge clk_in);
    sys_rst_in = 1'b0;
    @(negedge clk_in);
    t_lanes();
    t_back_to_back();
    t_sleep();
    tally_and_finish();
  end
endmodule : ast_ctrl_tb
